// [bench/sdd_display_config_asserts.sv]
`timescale 1ns/1ns
`default_nettype none
// ----
// Port checks of the display configuration block
// ----
module sdd_display_config_asserts
    import sdd_pkg::*;
#(
    parameter int unsigned MEM_WORDS = 16,
    parameter int unsigned DIV_FAST  = 2,
    parameter int unsigned DIV_SLOW  = 4
)
(
    input wire logic          clk_sys,
    input wire logic          sys_rst,
    input wire sdd_sfr_req_t  sfr_req,
    input wire logic [7:0]    sfr_rdata,
    input wire logic          sfr_hit,
    input wire logic          sleep_power_mode,
    input wire logic          display_active,
    input wire logic          drive_clk,
    input wire logic          drive_tick,
    input wire logic          blink_active,
    input wire sdd_clock_t    clock_setting,
    input wire sdd_mux_t      multiplex_level,
    input wire logic          bias_third,
    input wire logic          ladder_select,
    input wire logic          charge_pump_on,
    input wire logic [5:0]    bias_level_select,
    input wire sdd_pin_role_t pin_role,
    input wire logic [15:0]   segment_pin_enable,
    input wire logic [7:0]    third_config,
    input wire logic [7:0]    seg_read_index,
    input wire logic [7:0]    seg_read_data
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    sequence high_then_low_s;
        drive_clk ##1 !drive_clk;
    endsequence
    sequence idle_two_s;
        !display_active [*2];
    endsequence
    tick_edge_a: assert property (drive_tick |-> high_then_low_s)
        else $error("drive tick not at end of high phase");
    idle_clock_a: assert property (idle_two_s |-> !drive_clk)
        else $error("drive clock runs while inactive");
    mux_reserved_a: assert property
        (multiplex_level == SDD_MUX_RSVD |-> !display_active)
        else $error("reserved mux level drives display");
    mux_two_a: assert property (multiplex_level == SDD_MUX_2 |->
        !pin_role.shared_a_is_common && !pin_role.shared_b_is_common)
        else $error("two-way mux pin roles wrong");
    mux_three_a: assert property (multiplex_level == SDD_MUX_3 |->
        !pin_role.shared_a_is_common && pin_role.shared_b_is_common)
        else $error("three-way mux pin roles wrong");
    mux_four_a: assert property (multiplex_level == SDD_MUX_4 |->
        pin_role.shared_a_is_common && pin_role.shared_b_is_common)
        else $error("four-way mux pin roles wrong");
    pump_ladder_a: assert property (charge_pump_on != ladder_select)
        else $error("charge pump and ladder both on or off");
    blink_gate_a: assert property (blink_active |-> display_active)
        else $error("blink active while display off");
    clock_write_a: assert property (sfr_req.wr &&
        sfr_req.addr == 8'h96 |=> clock_setting == $past(sfr_req.wdata))
        else $error("clock register write lost");
    segen_write_a: assert property (sfr_req.wr && sfr_req.addr == 8'hed
        |=> segment_pin_enable[15:8] == $past(sfr_req.wdata))
        else $error("second segment enable write lost");
    reg_hit_a: assert property (sfr_hit == (sfr_req.addr inside
        {8'h95, 8'h96, 8'h97, 8'h9c, 8'hac, 8'hae, 8'hb1, 8'hed}))
        else $error("register decode wrong");
    miss_zero_a: assert property (!sfr_hit |-> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule : sdd_display_config_asserts

bind sdd_display_config sdd_display_config_asserts #(
    .MEM_WORDS(MEM_WORDS), .DIV_FAST(DIV_FAST), .DIV_SLOW(DIV_SLOW)
) u_asserts (
    .clk_sys, .sys_rst, .sfr_req, .sfr_rdata, .sfr_hit, .sleep_power_mode,
    .display_active, .drive_clk, .drive_tick, .blink_active, .clock_setting,
    .multiplex_level, .bias_third, .ladder_select, .charge_pump_on,
    .bias_level_select, .pin_role, .segment_pin_enable, .third_config,
    .seg_read_index, .seg_read_data
);
`default_nettype wire

// [bench/sdd_panel_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ----
// Glass panel: scans one segment word per drive tick
// ----
module sdd_panel_model
(
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    input  wire logic       drive_tick,
    input  wire logic       display_active,
    input  wire logic [7:0] seg_read_data,
    output logic [7:0]      seg_read_index
);
    logic [3:0] row_q;
    logic [3:0] last_q;
    logic [7:0] frame_q [16];
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            row_q <= 4'h0;
        else if (display_active && drive_tick)
            row_q <= row_q + 4'h1;
    end
    // Read data lags the index by one cycle
    always_ff @(posedge clk_sys)
    begin
        last_q <= row_q;
        frame_q[last_q] <= seg_read_data;
    end
    assign seg_read_index = {4'h0, row_q};
endmodule : sdd_panel_model
`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
// ----
// Register-level test of the display configuration block
// ----
module tb_top;
    import sdd_pkg::*;
    logic          clk_sys;
    logic          sys_rst;
    sdd_sfr_req_t  sfr_req;
    logic [7:0]    sfr_rdata;
    logic          sfr_hit;
    logic          sleep_power_mode;
    logic          display_active;
    logic          drive_clk;
    logic          drive_tick;
    logic          blink_active;
    sdd_clock_t    clock_setting;
    sdd_mux_t      multiplex_level;
    logic          bias_third;
    logic          ladder_select;
    logic          charge_pump_on;
    logic [5:0]    bias_level_select;
    sdd_pin_role_t pin_role;
    logic [15:0]   segment_pin_enable;
    logic [7:0]    third_config;
    logic [7:0]    seg_read_index;
    logic [7:0]    seg_read_data;
    logic [7:0]    k;
    int            n_errors;
    int            check_count;
    logic [7:0]    ra [8] = '{8'h95, 8'h96, 8'h97, 8'h9c,
                              8'hac, 8'hae, 8'hb1, 8'hed};
    logic [7:0]    rw [8] = '{8'h01, 8'hc7, 8'h3c, 8'hff,
                              8'h03, 8'h5a, 8'h42, 8'hc0};
    logic [7:0]    re [8] = '{8'h01, 8'hc7, 8'h3c, 8'h7f,
                              8'h03, 8'h5a, 8'h42, 8'hc0};
    logic [3:0]    roles [4] = '{4'h3, 4'h3, 4'h7, 4'hf};

    sdd_display_config #(.MEM_WORDS(16), .DIV_FAST(2), .DIV_SLOW(4)) DUT (
        .clk_sys, .sys_rst, .sfr_req, .sfr_rdata, .sfr_hit,
        .sleep_power_mode, .display_active, .drive_clk, .drive_tick,
        .blink_active, .clock_setting, .multiplex_level, .bias_third,
        .ladder_select, .charge_pump_on, .bias_level_select, .pin_role,
        .segment_pin_enable, .third_config, .seg_read_index, .seg_read_data
    );
    sdd_panel_model u_panel (
        .clk_sys, .sys_rst, .drive_tick, .display_active, .seg_read_data,
        .seg_read_index
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        check_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        sfr_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk_sys);
        sfr_req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_sys);
        sfr_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        #10;
        chk("register read", e, sfr_rdata);
    endtask : rd

    // Cycles between two drive ticks, bounded
    task automatic period(input logic [7:0] e);
        int c;
        int r;
        c = 0;
        r = 0;
        while (r < 2)
        begin
            @(negedge clk_sys);
            c++;
            if (drive_tick === 1'b1)
            begin
                r++;
                if (r == 1)
                    c = 0;
            end
            if (c > 200)
            begin
                n_errors++;
                tally_and_finish();
            end
        end
        chk("drive period", e, c[7:0]);
    endtask : period

    initial
    begin
        n_errors = 0;
        check_count = 0;
        sys_rst = 1'b1;
        sfr_req = '0;
        sleep_power_mode = 1'b0;
        repeat (20) @(negedge clk_sys);
        sys_rst = 1'b0;
        rd(8'h95, 8'h00);
        rd(8'h9c, 8'h00);
        chk("pump", 8'h01, {7'h0, charge_pump_on});
        for (int i = 0; i < 8; i++)
        begin
            wr(ra[i], rw[i]);
            rd(ra[i], re[i]);
        end
        chk("ladder", 8'h02, {6'h0, ladder_select, charge_pump_on});
        chk("bias lvl", 8'h3f, {2'h0, bias_level_select});
        chk("third", 8'h42, third_config);
        chk("clock", 8'hc7, clock_setting);
        chk("segen lo", 8'h3c, segment_pin_enable[7:0]);
        chk("pin role", 8'h03, {4'h0, pin_role});
        wr(8'h95, 8'h06);
        chk("bias mux", 8'h06, {5'h0, bias_third, multiplex_level});
        rd(8'h98, 8'h00);
        chk("hit", 8'h00, {7'h0, sfr_hit});
        for (k = 0; k < 16; k++)
        begin
            wr(8'hac, k);
            wr(8'hae, k ^ 8'h5a);
        end
        wr(8'hac, 8'h10);
        wr(8'hae, 8'hff);
        rd(8'hae, 8'h00);
        wr(8'h95, 8'h81);
        repeat (100) @(negedge clk_sys);
        for (k = 0; k < 16; k++)
            chk("panel", k ^ 8'h5a, u_panel.frame_q[k[3:0]]);
        period(8'h04);
        wr(8'h95, 8'h89);
        period(8'h08);
        wr(8'h95, 8'h01);
        repeat (3) @(negedge clk_sys);
        chk("off", 8'h00, {6'h0, display_active, drive_clk});
        for (int m = 0; m < 4; m++)
        begin
            wr(8'h95, 8'h80 | 8'(m));
            chk("active", {7'h0, m != 0}, {7'h0, display_active});
            chk("roles", {4'h0, roles[m]}, {4'h0, pin_role});
        end
        // Software has the reference on before relying on sleep
        wr(8'h95, 8'h81);
        sleep_power_mode = 1'b1;
        repeat (3) @(negedge clk_sys);
        chk("sleep on", 8'h01, {7'h0, display_active});
        wr(8'h95, 8'hb1);
        chk("sleep off", 8'h00, {7'h0, display_active});
        sleep_power_mode = 1'b0;
        repeat (3) @(negedge clk_sys);
        chk("blink", 8'h01, {7'h0, blink_active});
        wr(8'h95, 8'hc1);
        rd(8'h95, 8'h81);
        for (k = 0; k < 16; k++)
        begin
            wr(8'hac, k);
            rd(8'hae, 8'h00);
        end
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire

// [hw/sdd_cfg.svh]
`ifndef SDD_CFG_SVH
`define SDD_CFG_SVH
// Register addresses on the special function register bus
`define SDD_ADDR_MAIN      8'h95
`define SDD_ADDR_CLOCK     8'h96
`define SDD_ADDR_SEGEN1    8'h97
`define SDD_ADDR_SECOND    8'h9c
`define SDD_ADDR_POINTER   8'hac
`define SDD_ADDR_DATA      8'hae
`define SDD_ADDR_THIRD     8'hb1
`define SDD_ADDR_SEGEN2    8'hed
// Main configuration fields
`define SDD_BIT_ENABLE     7
`define SDD_BIT_CLEAR      6
`define SDD_BIT_BLINK      5
`define SDD_BIT_SLEEP_OFF  4
`define SDD_BIT_DRIVE_CLOCK_SELECT     3
`define SDD_BIT_BIAS       2
`define SDD_MUX_HI         1
`define SDD_MUX_LO         0
// Secondary configuration fields
`define SDD_BIT_LADDER     6
`define SDD_BIAS_LVL_HI    5
`define SDD_BIAS_LVL_LO    0
// Clock register fields
`define SDD_BLK_SRC_HI     7
`define SDD_BLK_SRC_LO     6
`define SDD_BLK_RATE_HI    5
`define SDD_BLK_RATE_LO    4
`define SDD_FRAME_HI       3
`define SDD_FRAME_LO       0
// Reset values
`define SDD_RST_MAIN       8'h00
`define SDD_RST_CLOCK      8'h00
`define SDD_RST_SEGEN      8'h00
`define SDD_RST_SECOND     8'h00
`define SDD_RST_THIRD      8'h00
`define SDD_RST_POINTER    8'h00
// Timing
`define SDD_SYS_HZ         20000000
`define SDD_DRIVE_FAST_HZ  2048
`define SDD_DRIVE_SLOW_HZ  128
`define SDD_DIV_FAST       (`SDD_SYS_HZ / (2 * `SDD_DRIVE_FAST_HZ))
`define SDD_DIV_SLOW       (`SDD_SYS_HZ / (2 * `SDD_DRIVE_SLOW_HZ))
`endif

// [hw/sdd_display_config.sv]
`timescale 1ns/1ns
`default_nettype none
`include "sdd_cfg.svh"
// How it works
// - Driver runs only while enable bit set
// - Clear bit zeroes every segment data register
// - Blink bit enables blinking per clock register
// - Sleep-off bit forces display off in sleep
// - Clock select: 2048 Hz clear, 128 Hz set
// - Mux 00 reserved; 01 both pins segments
// - Mux 10: pin a segment, b common
// - Mux 11: both shared pins are commons
// - Ladder bit: ladder on, charge pump off
// - Drives up to 16 segments by 4 commons
// - Works in all power modes, sleep-gated
// - Shared pin needs its segment-enable bit
// - Clock register sets frame and blink rates
// - Eight registers readable and writable by address
module sdd_display_config
    import sdd_pkg::*;
#(
    parameter int unsigned MEM_WORDS = 16,
    parameter int unsigned DIV_FAST  = `SDD_DIV_FAST,
    parameter int unsigned DIV_SLOW  = `SDD_DIV_SLOW
)
(
    input  wire logic          clk_sys,
    input  wire logic          sys_rst,
    input  wire sdd_sfr_req_t  sfr_req,
    output logic [7:0]         sfr_rdata,
    output logic               sfr_hit,
    input  wire logic          sleep_power_mode,
    output logic               display_active,
    output logic               drive_clk,
    output logic               drive_tick,
    output logic               blink_active,
    output sdd_clock_t         clock_setting,
    output sdd_mux_t           multiplex_level,
    output logic               bias_third,
    output logic               ladder_select,
    output logic               charge_pump_on,
    output logic [5:0]         bias_level_select,
    output sdd_pin_role_t      pin_role,
    output logic [15:0]        segment_pin_enable,
    output logic [7:0]         third_config,
    input  wire logic [7:0]    seg_read_index,
    output logic [7:0]         seg_read_data
);
    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    localparam int AW = $clog2(MEM_WORDS);

    initial
    begin
        if (MEM_WORDS < 9 || MEM_WORDS > 256)
            $error("sdd_display_config: MEM_WORDS out of range");
        if (DIV_FAST < 1 || DIV_SLOW < DIV_FAST)
            $error("sdd_display_config: drive dividers out of range");
    end

    // ------------------------------------------------------------
    // Sleep input synchroniser
    // ------------------------------------------------------------
    logic sleep_meta_q;
    logic sleep_q;

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sleep_meta_q <= 1'b0;
            sleep_q      <= 1'b0;
        end
        else
        begin
            sleep_meta_q <= sleep_power_mode;
            sleep_q      <= sleep_meta_q;
        end
    end

    // ------------------------------------------------------------
    // Register write decode
    // ------------------------------------------------------------
    function automatic logic wr_hit(input sdd_sfr_req_t r,
                                    input logic [7:0] a);
        return r.wr && (r.addr == a);
    endfunction : wr_hit

    // Index check kept one bit wider so a full 256-word memory still fits
    function automatic logic mem_ok(input logic [7:0] idx);
        return {1'b0, idx} < 9'(MEM_WORDS);
    endfunction : mem_ok

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    sdd_main_t  main_q;
    sdd_clock_t clock_q;
    logic [7:0] segen1_q;
    logic [7:0] segen2_q;
    logic [7:0] second_q;
    logic [7:0] third_q;
    logic [7:0] pointer_q;
    logic [7:0] mem_q [MEM_WORDS];
    logic       clear_req;
    logic       data_wr;

    // Clear bit is self-clearing: a write with it set zeroes memory
    assign clear_req = wr_hit(sfr_req, `SDD_ADDR_MAIN)
                       && sfr_req.wdata[`SDD_BIT_CLEAR];
    assign data_wr   = wr_hit(sfr_req, `SDD_ADDR_DATA)
                       && mem_ok(pointer_q);

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            main_q <= sdd_main_t'(`SDD_RST_MAIN);
        else if (wr_hit(sfr_req, `SDD_ADDR_MAIN))
        begin
            main_q                    <= sdd_main_t'(sfr_req.wdata);
            main_q.segment_data_clear <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            clock_q <= sdd_clock_t'(`SDD_RST_CLOCK);
        else if (wr_hit(sfr_req, `SDD_ADDR_CLOCK))
            clock_q <= sdd_clock_t'(sfr_req.wdata);
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            segen1_q <= `SDD_RST_SEGEN;
            segen2_q <= `SDD_RST_SEGEN;
        end
        else
        begin
            if (wr_hit(sfr_req, `SDD_ADDR_SEGEN1))
                segen1_q <= sfr_req.wdata;
            if (wr_hit(sfr_req, `SDD_ADDR_SEGEN2))
                segen2_q <= sfr_req.wdata;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            second_q <= `SDD_RST_SECOND;
            third_q  <= `SDD_RST_THIRD;
        end
        else
        begin
            if (wr_hit(sfr_req, `SDD_ADDR_SECOND))
                second_q <= sfr_req.wdata & 8'h7f;
            if (wr_hit(sfr_req, `SDD_ADDR_THIRD))
                third_q <= sfr_req.wdata;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            pointer_q <= `SDD_RST_POINTER;
        else if (wr_hit(sfr_req, `SDD_ADDR_POINTER))
            pointer_q <= sfr_req.wdata;
    end

    // ------------------------------------------------------------
    // Segment memory
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < MEM_WORDS; i++)
                mem_q[i] <= 8'h00;
        end
        else if (clear_req)
        begin
            for (int i = 0; i < MEM_WORDS; i++)
                mem_q[i] <= 8'h00;
        end
        // Writes beyond the memory are dropped; a clear beats a data write
        else if (data_wr)
            mem_q[pointer_q[AW-1:0]] <= sfr_req.wdata;
    end

    // ------------------------------------------------------------
    // Display-side read port
    // ------------------------------------------------------------
    // Rows past the memory scan out blank
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            seg_read_data <= 8'h00;
        else if (mem_ok(seg_read_index))
            seg_read_data <= mem_q[seg_read_index[AW-1:0]];
        else
            seg_read_data <= 8'h00;
    end

    // ------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------
    always_comb
    begin
        // Clear bit of the main register always reads back 0
        sfr_hit   = 1'b1;
        sfr_rdata = 8'h00;
        case (sfr_req.addr)
            `SDD_ADDR_MAIN:    sfr_rdata = main_q;
            `SDD_ADDR_CLOCK:   sfr_rdata = clock_q;
            `SDD_ADDR_SEGEN1:  sfr_rdata = segen1_q;
            `SDD_ADDR_SECOND:  sfr_rdata = second_q;
            `SDD_ADDR_POINTER: sfr_rdata = pointer_q;
            `SDD_ADDR_DATA:
            begin
                if (mem_ok(pointer_q))
                    sfr_rdata = mem_q[pointer_q[AW-1:0]];
            end
            `SDD_ADDR_THIRD:   sfr_rdata = third_q;
            `SDD_ADDR_SEGEN2:  sfr_rdata = segen2_q;
            default:           sfr_hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Driver state
    // ------------------------------------------------------------
    logic sleep_blank;
    logic mux_valid;

    // Sleep gating keeps the driver alive in every other mode
    assign sleep_blank    = sleep_q && main_q.sleep_display_off;
    assign mux_valid      = main_q.multiplex_level != SDD_MUX_RSVD;
    assign display_active = main_q.display_enable
                            && !sleep_blank && mux_valid;
    // Reference for sleep operation is software's duty
    assign blink_active   = display_active && main_q.blink_enable;
    assign clock_setting  = clock_q;
    assign multiplex_level = main_q.multiplex_level;
    assign bias_third     = main_q.bias_third;
    assign ladder_select  = second_q[`SDD_BIT_LADDER];
    assign charge_pump_on = !second_q[`SDD_BIT_LADDER];
    assign bias_level_select = second_q[`SDD_BIAS_LVL_HI:`SDD_BIAS_LVL_LO];
    assign third_config   = third_q;
    assign segment_pin_enable = {segen2_q, segen1_q};

    // ------------------------------------------------------------
    // Shared pin roles
    // ------------------------------------------------------------
    always_comb
    begin
        pin_role = '0;
        case (main_q.multiplex_level)
            SDD_MUX_2:
            begin
                pin_role.shared_a_is_common = 1'b0;
                pin_role.shared_b_is_common = 1'b0;
            end
            SDD_MUX_3:
            begin
                pin_role.shared_a_is_common = 1'b0;
                pin_role.shared_b_is_common = 1'b1;
            end
            SDD_MUX_4:
            begin
                pin_role.shared_a_is_common = 1'b1;
                pin_role.shared_b_is_common = 1'b1;
            end
            default:
                pin_role = '0;
        endcase
        // Shared pins are the top two enable bits of the second register
        pin_role.shared_a_enabled = segen2_q[6];
        pin_role.shared_b_enabled = segen2_q[7];
    end

    // ------------------------------------------------------------
    // Drive clock
    // ------------------------------------------------------------
    sdd_drive_clock #(
        .DIV_FAST (DIV_FAST),
        .DIV_SLOW (DIV_SLOW)
    ) u_drive_clock (
        .clk_sys     (clk_sys),
        .sys_rst     (sys_rst),
        .run         (display_active),
        .slow_select (main_q.drive_clock_select),
        .drive_clk   (drive_clk),
        .drive_tick  (drive_tick)
    );
endmodule : sdd_display_config
`default_nettype wire

// [hw/sdd_drive_clock.sv]
`timescale 1ns/1ns
`default_nettype none
`include "sdd_cfg.svh"
// Divides the system clock into the selected display drive clock tick
module sdd_drive_clock
    import sdd_pkg::*;
#(
    parameter int unsigned DIV_FAST = `SDD_DIV_FAST,
    parameter int unsigned DIV_SLOW = `SDD_DIV_SLOW
)
(
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic run,
    input  wire logic slow_select,
    output logic      drive_clk,
    output logic      drive_tick
);
    localparam int CW = $clog2(DIV_SLOW + 1);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] limit;

    initial
    begin
        if (DIV_FAST < 1 || DIV_SLOW < DIV_FAST)
            $error("sdd_drive_clock: bad divider");
    end

    assign limit = slow_select ? CW'(DIV_SLOW - 1) : CW'(DIV_FAST - 1);

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            cnt_q <= '0;
        else if (!run || cnt_q >= limit)
            cnt_q <= '0;
        else
            cnt_q <= cnt_q + CW'(1);
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            drive_clk <= 1'b0;
        else if (!run)
            drive_clk <= 1'b0;
        else if (cnt_q >= limit)
            drive_clk <= ~drive_clk;
    end

    assign drive_tick = run && (cnt_q >= limit) && drive_clk;
endmodule : sdd_drive_clock
`default_nettype wire

// [hw/sdd_pkg.sv]
package sdd_pkg;
    typedef enum logic [1:0]
    {
        SDD_MUX_RSVD = 2'h0,
        SDD_MUX_2    = 2'h1,
        SDD_MUX_3    = 2'h2,
        SDD_MUX_4    = 2'h3
    } sdd_mux_t;

    typedef struct packed
    {
        logic     display_enable;
        logic     segment_data_clear;
        logic     blink_enable;
        logic     sleep_display_off;
        logic     drive_clock_select;
        logic     bias_third;
        sdd_mux_t multiplex_level;
    } sdd_main_t;

    typedef struct packed
    {
        logic [1:0] blink_source;
        logic [1:0] blink_rate;
        logic [3:0] frame_divide;
    } sdd_clock_t;

    typedef struct packed
    {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sdd_sfr_req_t;

    typedef struct packed
    {
        logic shared_a_is_common;
        logic shared_b_is_common;
        logic shared_a_enabled;
        logic shared_b_enabled;
    } sdd_pin_role_t;
endpackage : sdd_pkg
